// >>> bench/acr_core_model.sv
// Purpose: Behavioural converter core, done pulse a fixed time after start
// Assumes: Start and abort are one-cycle pulses
// Notes: Data lines show the inverse of the previous cycle's data outside done
`timescale 1ns/1ns
module acr_core_model #(
    parameter int LATENCY = 6       // Cycles from start to done
) (
    input  wire logic       clk,       // Clock
    input  wire logic       srst,      // Sync reset
    input  wire logic       convStart, // Start pulse
    input  wire logic       convAbort, // Abort pulse
    input  wire logic [9:0] sample,    // Value to convert
    output logic            convDone,  // Done pulse
    output logic [9:0]      convData   // Result, valid with done
);
    int         count_q;
    logic [9:0] last_q;
    // Countdown; a start restarts it, a lone abort cancels it
    always_ff @(posedge clk) begin
        if (srst || (convAbort && !convStart)) begin
            count_q <= 0;
        end else if (convStart) begin
            count_q <= LATENCY;
        end else if (count_q > 0) begin
            count_q <= count_q - 1;
        end
        last_q <= srst ? 10'h000 : convData;
    end
    // Stale data inverts the previous cycle's data, so it repeats the last result every other cycle
    assign convDone = (count_q == 1);
    assign convData = convDone ? sample : ~last_q;
endmodule // acr_core_model

// >>> bench/adc_control_compare_result_tb_top.sv
// Purpose: Self-checking bench for the converter control block
// Assumes: Core model answers a start after six cycles
// Notes: Registers reached over the plain strobe port
`timescale 1ns/1ns
module adc_control_compare_result_tb_top;
    import acr_pkg::*;
    logic        clk, srst, hwTrigger, alternate_clock_input, asyncClk;
    logic        convDone, convStart, convAbort, convOff, convTick;
    logic [9:0]  convData, sample;
    logic [7:0]  rdata;
    logic [4:0]  convChannel;
    logic [15:0] cyc;
    acr_bus_t    bus;
    acr_cfg_t    convCfg;
    int          num_errors = 0;
    int          checked = 0;
    int          n;
    logic [7:0]  cfgs [7] = '{8'h00, 8'h20, 8'h40, 8'hF0, 8'h01, 8'h02, 8'h33};
    logic [9:0]  ticks [7] = '{10'h050, 10'h028, 10'h014, 10'h00A, 10'h028, 10'h014, 10'h005};

    acr_control dut (.clk(clk), .srst(srst), .bus(bus), .rdata(rdata), .hwTrigger(hwTrigger),
        .alternate_clock_input(alternate_clock_input), .asyncClk(asyncClk), .convDone(convDone), .convData(convData),
        .convStart(convStart), .convAbort(convAbort), .convOff(convOff),
        .convChannel(convChannel), .convTick(convTick), .convCfg(convCfg));
    acr_core_model core (.clk(clk), .srst(srst), .convStart(convStart), .convAbort(convAbort),
        .sample(sample), .convDone(convDone), .convData(convData));

    // Clock, 10 ns period
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Slow source levels and a ceiling on the run
    always @(posedge clk) begin
        cyc <= cyc + 16'h0001;
        alternate_clock_input <= cyc[1];
        asyncClk <= cyc[2];
        if (cyc == 16'h4E20) begin
            num_errors++;
            wrap_up();
        end
    end

    task automatic check(string what, logic [9:0] seen, logic [9:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(logic [2:0] a, logic [7:0] d);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus <= '0;
        @(posedge clk);
    endtask
    task automatic rd(logic [2:0] a, logic [7:0] exp);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus <= '0;
        @(negedge clk);
        check("rdata", 10'(rdata), 10'(exp));
        @(posedge clk);
    endtask
    // Software start, active flag seen while busy, clear after
    task automatic convert(logic [7:0] trig, logic [9:0] v);
        sample <= v;
        wr(ADDR_TRIGCMP, trig);
        wr(ADDR_STATUS1, 8'h03);
        rd(ADDR_TRIGCMP, trig | 8'h80);
        for (int i = 0; i < 20; i++) begin
            @(negedge clk);
            if (convDone) break;
        end
        check("convDone", 10'(convDone), 10'h001);
        @(posedge clk);
        @(posedge clk);
        rd(ADDR_TRIGCMP, trig);
    endtask
    task automatic row(logic [7:0] trig, logic [9:0] v, logic [7:0] hi, logic [7:0] lo,
                       logic done);
        convert(trig, v);
        rd(ADDR_STATUS1, {done, 7'h03});
        rd(ADDR_RESHIGH, hi);
        rd(ADDR_RESLOW, lo);
        rd(ADDR_STATUS1, 8'h03);
    endtask
    task automatic wrap_up();
        $display("checked %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // Main sequence
    initial begin
        bus = '0;
        hwTrigger = 1'b0;
        sample = 10'h000;
        cyc = 16'h0000;
        alternate_clock_input = 1'b0;
        asyncClk = 1'b0;
        srst = 1'b1;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        for (int a = 0; a < 8; a++) rd(3'(a), a == 0 ? 8'h1F : 8'h00);
        wr(ADDR_TRIGCMP, 8'hF0);
        rd(ADDR_TRIGCMP, 8'h70);
        wr(ADDR_RESHIGH, 8'hFF);
        rd(ADDR_RESHIGH, 8'h00);
        wr(ADDR_CMPLOW, 8'h5A);
        rd(ADDR_CMPLOW, 8'h5A);
        // Converter clock rate per source and divide setting
        foreach (cfgs[i]) begin
            wr(ADDR_CONFIG, cfgs[i]);
            rd(ADDR_CONFIG, cfgs[i]);
            repeat (16) @(posedge clk);
            n = 0;
            repeat (80) begin
                @(negedge clk);
                n += int'(convTick);
            end
            check("convTick", 10'(n), ticks[i]);
            check("convCfg", 10'(convCfg), 10'(cfgs[i]));
            @(posedge clk);
        end
        // Compare modes in ten-bit, then eight-bit
        wr(ADDR_CONFIG, 8'h08);
        wr(ADDR_CMPHIGH, 8'h02);
        wr(ADDR_CMPLOW, 8'h00);
        row(8'h00, 10'h2A5, 8'h02, 8'hA5, 1'b1);
        row(8'h20, 10'h1FF, 8'h01, 8'hFF, 1'b1);
        row(8'h20, 10'h200, 8'h01, 8'hFF, 1'b0);
        row(8'h30, 10'h200, 8'h02, 8'h00, 1'b1);
        row(8'h30, 10'h0FF, 8'h02, 8'h00, 1'b0);
        wr(ADDR_CONFIG, 8'h00);
        wr(ADDR_CMPLOW, 8'h50);
        row(8'h30, 10'h060, 8'h00, 8'h60, 1'b1);
        row(8'h20, 10'h060, 8'h00, 8'h60, 1'b0);
        row(8'h00, 10'h3C7, 8'h00, 8'hC7, 1'b1);
        // Ten-bit interlock loses a result finishing between reads, eight-bit mode has no interlock
        wr(ADDR_CONFIG, 8'h08);
        convert(8'h00, 10'h2A5);
        rd(ADDR_RESHIGH, 8'h02);
        convert(8'h00, 10'h155);
        rd(ADDR_RESHIGH, 8'h02);
        rd(ADDR_RESLOW, 8'hA5);
        convert(8'h00, 10'h155);
        rd(ADDR_RESHIGH, 8'h01);
        rd(ADDR_RESLOW, 8'h55);
        wr(ADDR_CONFIG, 8'h00);
        convert(8'h00, 10'h012);
        rd(ADDR_RESHIGH, 8'h00);
        convert(8'h00, 10'h034);
        rd(ADDR_RESLOW, 8'h34);
        // Hardware trigger start
        wr(ADDR_TRIGCMP, 8'h40);
        sample <= 10'h077;
        hwTrigger <= 1'b1;
        @(negedge clk);
        check("convStart", 10'(convStart), 10'h001);
        @(posedge clk);
        hwTrigger <= 1'b0;
        repeat (8) @(posedge clk);
        rd(ADDR_RESLOW, 8'h77);
        // Abort by switching the converter off mid-run
        wr(ADDR_TRIGCMP, 8'h00);
        wr(ADDR_STATUS1, 8'h03);
        check("convChannel", 10'(convChannel), 10'h003);
        bus <= '{addr: ADDR_STATUS1, wdata: 8'h1F, wr: 1'b1, rd: 1'b0};
        @(negedge clk);
        check("convAbort", 10'(convAbort), 10'h001);
        check("convStart", 10'(convStart), 10'h000);
        @(posedge clk);
        bus <= '0;
        @(posedge clk);
        check("convOff", 10'(convOff), 10'h001);
        rd(ADDR_TRIGCMP, 8'h00);
        wrap_up();
    end
endmodule // adc_control_compare_result_tb_top

// >>> design/acr_control.sv
// Purpose: Converter control, compare and result registers with read interlock
// Assumes: Converter core takes start/abort and returns a done pulse with data
// Notes: Register reads answer one cycle after the read strobe
//
// The strobed register port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
module acr_control (
    input  wire logic             clk,          // 100 MHz clock
    input  wire logic             srst,         // Sync reset, active high
    input  wire acr_pkg::acr_bus_t bus,         // Register port command
    output logic [7:0]            rdata,        // Read data, cycle after strobe
    input  wire logic             hwTrigger,    // Hardware trigger input
    input  wire logic             alternate_clock_input,       // Alternate clock input level
    input  wire logic             asyncClk,     // Async clock input level
    input  wire logic             convDone,     // Core done pulse
    input  wire logic [9:0]       convData,     // Core result
    output logic                  convStart,    // Start pulse to core
    output logic                  convAbort,    // Abort pulse to core
    output logic                  convOff,      // Converter powered off
    output logic [4:0]            convChannel,  // Selected channel
    output logic                  convTick,     // Converter clock enable
    output acr_pkg::acr_cfg_t     convCfg       // Config to core
);
    import acr_pkg::*;

    logic       complete_q;
    logic [4:0] chan_q;
    logic       active_q;
    logic       trigSel_q;
    logic       cmpEn_q;
    logic       cmpGt_q;
    logic [1:0] cmpHigh_q;
    logic [7:0] cmpLow_q;
    acr_cfg_t   cfg_q;
    logic [9:0] result_q;
    logic       lock_q;
    logic       hwPrev_q;
    logic       altPrev_q;
    logic       asyncPrev_q;
    logic       half_q;
    logic [2:0] divCnt_q;
    logic       wrStatus;
    logic       rdHigh;
    logic       rdLow;
    logic       hwEdge;
    logic       startReq;
    logic       is10;
    logic [9:0] cmpVal;
    logic [9:0] resVal;
    logic       cmpTrue;
    logic       accept;
    logic       srcTick;
    logic [2:0] divMax;

    // Strobe decode
    assign wrStatus = bus.wr && (bus.addr == ADDR_STATUS1);
    assign rdHigh   = bus.rd && (bus.addr == ADDR_RESHIGH);
    assign rdLow    = bus.rd && (bus.addr == ADDR_RESLOW);
    assign hwEdge   = hwTrigger && !hwPrev_q;
    assign is10     = (cfg_q.resMode == RES_10BIT);

    // Start request from the selected trigger
    always_comb begin
        if (trigSel_q) begin
            startReq = hwEdge && (chan_q != CHAN_OFF); // R2
        end else begin
            startReq = wrStatus && (bus.wdata[4:0] != CHAN_OFF); // R2 R21
        end
    end
    assign convStart = startReq;
    assign convAbort = wrStatus && active_q; // R21
    assign convOff   = (chan_q == CHAN_OFF); // R22
    assign convChannel = chan_q;
    assign convCfg   = cfg_q; // R15 R17 R18

    // Compare operands
    always_comb begin
        if (is10) begin
            cmpVal = {cmpHigh_q, cmpLow_q}; // R13 R24
            resVal = convData;
        end else begin
            cmpVal = {2'h0, cmpLow_q}; // R13 R14
            resVal = {2'h0, convData[7:0]};
        end
    end
    assign cmpTrue = cmpGt_q ? (resVal >= cmpVal) : (resVal < cmpVal); // R4
    assign accept  = convDone && active_q && (!cmpEn_q || cmpTrue); // R3 R6

    // Hardware trigger edge history
    always_ff @(posedge clk) begin
        if (srst) begin
            hwPrev_q <= 1'b0;
        end else begin
            hwPrev_q <= hwTrigger;
        end
    end

    // First status register: channel field
    always_ff @(posedge clk) begin
        if (srst) begin
            chan_q <= RESET_CHAN;
        end else if (wrStatus) begin
            chan_q <= bus.wdata[4:0];
        end
    end

    // Conversion active flag
    always_ff @(posedge clk) begin
        if (srst) begin
            active_q <= 1'b0;
        end else if (startReq) begin
            active_q <= 1'b1; // R1
        end else if (convAbort || (convDone && active_q)) begin
            active_q <= 1'b0; // R1
        end
    end

    // Complete flag: set wins over the low-result read clear, a status write clears
    always_ff @(posedge clk) begin
        if (srst) begin
            complete_q <= 1'b0;
        end else if (accept && !convAbort) begin
            complete_q <= 1'b1; // R20
        end else if (wrStatus || rdLow) begin
            complete_q <= 1'b0; // R20
        end
    end

    // Trigger and compare control, active bit not writable
    always_ff @(posedge clk) begin
        if (srst) begin
            trigSel_q <= 1'b0;
            cmpEn_q   <= 1'b0;
            cmpGt_q   <= 1'b0;
        end else if (bus.wr && bus.addr == ADDR_TRIGCMP) begin
            trigSel_q <= bus.wdata[BIT_TRIGSEL]; // R2
            cmpEn_q   <= bus.wdata[BIT_CMPEN]; // R3
            cmpGt_q   <= bus.wdata[BIT_CMPGT]; // R4 R23
        end
    end

    // Compare value and configuration registers
    always_ff @(posedge clk) begin
        if (srst) begin
            cmpHigh_q <= 2'h0;
            cmpLow_q  <= RESET_BYTE;
            cfg_q     <= acr_cfg_t'(RESET_BYTE);
        end else if (bus.wr) begin
            if (bus.addr == ADDR_CMPHIGH) begin
                cmpHigh_q <= bus.wdata[1:0];
            end
            if (bus.addr == ADDR_CMPLOW) begin
                cmpLow_q <= bus.wdata;
            end
            if (bus.addr == ADDR_CONFIG) begin
                cfg_q <= acr_cfg_t'(bus.wdata); // R18 R12
            end
        end
    end

    // Read interlock, 10-bit mode only
    always_ff @(posedge clk) begin
        if (srst) begin
            lock_q <= 1'b0;
        end else if (rdLow || !is10) begin
            lock_q <= 1'b0; // R11
        end else if (rdHigh) begin
            lock_q <= 1'b1; // R9
        end
    end

    // Result transfer
    always_ff @(posedge clk) begin
        if (srst) begin
            result_q <= 10'h000;
        end else if (accept && !lock_q) begin
            result_q <= is10 ? convData : {2'h0, convData[7:0]}; // R6 R7 R8 R10
        end
    end

    // Clock source edges, sampled as levels
    always_ff @(posedge clk) begin
        if (srst) begin
            altPrev_q   <= 1'b0;
            asyncPrev_q <= 1'b0;
            half_q      <= 1'b0;
        end else begin
            altPrev_q   <= alternate_clock_input;
            asyncPrev_q <= asyncClk;
            half_q      <= !half_q;
        end
    end

    // Source selection
    always_comb begin
        unique case (cfg_q.clkSel)
            2'h0: srcTick = 1'b1; // R19
            2'h1: srcTick = half_q;
            2'h2: srcTick = alternate_clock_input && !altPrev_q;
            2'h3: srcTick = asyncClk && !asyncPrev_q;
        endcase
    end

    // Divide ratio
    always_comb begin
        unique case (cfg_q.clkDiv)
            2'h0: divMax = 3'h0; // R16
            2'h1: divMax = 3'h1;
            2'h2: divMax = 3'h3;
            2'h3: divMax = 3'h7;
        endcase
    end

    // Divider counter
    always_ff @(posedge clk) begin
        if (srst) begin
            divCnt_q <= 3'h0;
        end else if (srcTick) begin
            divCnt_q <= (divCnt_q >= divMax) ? 3'h0 : divCnt_q + 3'h1; // R16
        end
    end
    assign convTick = srcTick && (divCnt_q >= divMax);

    // Read data, free of side effects except flags and lock
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata <= RESET_BYTE;
        end else if (bus.rd) begin
            unique case (bus.addr)
                ADDR_STATUS1: rdata <= {complete_q, 2'h0, chan_q};
                ADDR_TRIGCMP: rdata <= {active_q, trigSel_q, cmpEn_q, cmpGt_q, 4'h0}; // R23
                ADDR_RESHIGH: rdata <= {6'h00, result_q[9:8]}; // R7
                ADDR_RESLOW:  rdata <= result_q[7:0]; // R8
                ADDR_CMPHIGH: rdata <= {6'h00, cmpHigh_q};
                ADDR_CMPLOW:  rdata <= cmpLow_q;
                ADDR_CONFIG:  rdata <= cfg_q;
                default:      rdata <= RESET_BYTE;
            endcase
        end else begin
            rdata <= RESET_BYTE;
        end
    end

    // Checks
    lock_hold_a: assert property (@(posedge clk) disable iff (srst)
        lock_q && !rdLow && is10 |=> $stable(result_q))
        else $error("result changed while locked"); // R10
    lock_set_a: assert property (@(posedge clk) disable iff (srst)
        rdHigh && is10 && !rdLow |=> lock_q)
        else $error("lock not set"); // R9
    eight_nolock_a: assert property (@(posedge clk) disable iff (srst)
        !is10 |=> !lock_q)
        else $error("lock in 8-bit mode"); // R11
    active_set_a: assert property (@(posedge clk) disable iff (srst)
        convStart |=> active_q)
        else $error("active not set"); // R1
    active_clr_a: assert property (@(posedge clk) disable iff (srst)
        active_q && convDone && !startReq |=> !active_q)
        else $error("active not cleared"); // R1
    cmp_keep_a: assert property (@(posedge clk) disable iff (srst)
        convDone && cmpEn_q && !cmpTrue |=> $stable(result_q))
        else $error("result updated on false compare"); // R6
    complete_set_a: assert property (@(posedge clk) disable iff (srst)
        accept && !convAbort |=> complete_q)
        else $error("complete not set"); // R20
    off_start_a: assert property (@(posedge clk) disable iff (srst)
        wrStatus && bus.wdata[4:0] == CHAN_OFF |-> !convStart)
        else $error("start while off"); // R22
    high_zero_a: assert property (@(posedge clk) disable iff (srst)
        accept && !lock_q && !is10 |=> result_q[9:8] == 2'h0)
        else $error("upper bits nonzero in 8-bit"); // R7

    // Trigger source: only the selected trigger may start a conversion
    trig_sw_a: assert property (@(posedge clk) disable iff (srst)
        !trigSel_q && wrStatus && bus.wdata[4:0] != CHAN_OFF |-> convStart)
        else $error("software start missing"); // R2
    trig_swonly_a: assert property (@(posedge clk) disable iff (srst)
        !trigSel_q && !wrStatus |-> !convStart)
        else $error("start without status write"); // R2
    trig_hw_a: assert property (@(posedge clk) disable iff (srst)
        trigSel_q && hwEdge && !convOff |-> convStart)
        else $error("hardware start missing"); // R2
    trig_hwonly_a: assert property (@(posedge clk) disable iff (srst)
        trigSel_q && !hwEdge |-> !convStart)
        else $error("start without trigger edge"); // R2
    hw_off_a: assert property (@(posedge clk) disable iff (srst)
        trigSel_q && convOff |-> !convStart)
        else $error("hardware start while off"); // R22

    // Abort and restart on a status write
    abort_clr_a: assert property (@(posedge clk) disable iff (srst)
        convAbort && !startReq |=> !active_q)
        else $error("active kept after abort"); // R1
    start_abort_a: assert property (@(posedge clk) disable iff (srst)
        wrStatus && active_q |-> convAbort)
        else $error("status write did not abort"); // R21
    chan_load_a: assert property (@(posedge clk) disable iff (srst)
        wrStatus |=> convChannel == $past(bus.wdata[4:0]))
        else $error("channel not loaded"); // R21
    active_ro_a: assert property (@(posedge clk) disable iff (srst)
        bus.wr && bus.addr == ADDR_TRIGCMP && !startReq && !convAbort && !convDone
        |=> $stable(active_q))
        else $error("active bit written"); // R23

    // Result transfer and compare outcome
    result_free_a: assert property (@(posedge clk) disable iff (srst)
        !accept |=> $stable(result_q))
        else $error("result changed without completion"); // R6
    high_ten_a: assert property (@(posedge clk) disable iff (srst)
        accept && !lock_q && is10 |=> result_q == $past(convData))
        else $error("ten-bit result not stored"); // R7 R8
    low_eight_a: assert property (@(posedge clk) disable iff (srst)
        accept && !lock_q && !is10 |=> result_q[7:0] == $past(convData[7:0]))
        else $error("eight-bit result not stored"); // R8
    cmp_eight_a: assert property (@(posedge clk) disable iff (srst)
        !is10 |-> cmpVal[9:8] == 2'h0 && resVal[9:8] == 2'h0)
        else $error("upper compare bits used"); // R13
    cmp_lt_a: assert property (@(posedge clk) disable iff (srst)
        cmpEn_q && !cmpGt_q && convDone && active_q && !lock_q && is10
        && convData < {cmpHigh_q, cmpLow_q} |=> result_q == $past(convData))
        else $error("less-than compare lost result"); // R4 R24
    cmp_ge_a: assert property (@(posedge clk) disable iff (srst)
        cmpEn_q && cmpGt_q && convDone && !is10 && convData[7:0] < cmpLow_q
        |=> $stable(result_q))
        else $error("false greater compare stored"); // R4 R14
    cmp_off_a: assert property (@(posedge clk) disable iff (srst)
        convDone && active_q && !cmpEn_q && !convAbort |=> complete_q)
        else $error("complete missing with compare off"); // R3 R20

    // Complete flag clearing and holding
    complete_clr_a: assert property (@(posedge clk) disable iff (srst)
        (wrStatus || rdLow) && !accept |=> !complete_q)
        else $error("complete not cleared"); // R20
    complete_hold_a: assert property (@(posedge clk) disable iff (srst)
        !accept && !complete_q |=> !complete_q)
        else $error("complete set without completion"); // R20
    cmp_flag_a: assert property (@(posedge clk) disable iff (srst)
        convDone && cmpEn_q && !cmpTrue && !complete_q |=> !complete_q)
        else $error("complete set on false compare"); // R20

    // Interlock release
    unlock_a: assert property (@(posedge clk) disable iff (srst)
        rdLow |=> !lock_q)
        else $error("lock kept after low read"); // R9

    // Read data shape
    rd_idle_a: assert property (@(posedge clk) disable iff (srst)
        !bus.rd |=> rdata == RESET_BYTE)
        else $error("read data outside read"); // R23
    rd_high_a: assert property (@(posedge clk) disable iff (srst)
        bus.rd && bus.addr == ADDR_RESHIGH |=> rdata[7:2] == 6'h00)
        else $error("high result upper bits set"); // R7
    rd_trig_a: assert property (@(posedge clk) disable iff (srst)
        bus.rd && bus.addr == ADDR_TRIGCMP |=> rdata[3:0] == 4'h0)
        else $error("reserved control bits read back"); // R5 R23
    rd_status_a: assert property (@(posedge clk) disable iff (srst)
        bus.rd && bus.addr == ADDR_STATUS1 |=> rdata[6:5] == 2'h0)
        else $error("status spare bits set"); // R23
    cfg_load_a: assert property (@(posedge clk) disable iff (srst)
        bus.wr && bus.addr == ADDR_CONFIG |=> 8'(convCfg) == $past(bus.wdata))
        else $error("configuration not loaded"); // R15 R17 R18

    // Converter clock source and divider
    tick_src_a: assert property (@(posedge clk) disable iff (srst)
        convTick |-> srcTick)
        else $error("tick without source tick"); // R16
    tick_div1_a: assert property (@(posedge clk) disable iff (srst)
        cfg_q.clkSel == 2'h0 && cfg_q.clkDiv == 2'h0 |-> convTick)
        else $error("undivided bus clock tick missing"); // R16 R19
    half_src_a: assert property (@(posedge clk) disable iff (srst)
        cfg_q.clkSel == 2'h1 && srcTick && !(bus.wr && bus.addr == ADDR_CONFIG)
        |=> !srcTick)
        else $error("halved clock ticks twice"); // R19
    div_eight_a: assert property (@(posedge clk) disable iff (srst)
        cfg_q.clkDiv == 2'h3 && convTick && !(bus.wr && bus.addr == ADDR_CONFIG)
        |=> !convTick)
        else $error("divide by eight ticks twice"); // R16
    cover_hw_c: cover property (@(posedge clk) trigSel_q && convStart);
    cover_start_c: cover property (@(posedge clk) convStart ##[1:20] convDone);
    cover_lock_c: cover property (@(posedge clk) lock_q && convDone);
    cover_cmp_c: cover property (@(posedge clk) convDone && cmpEn_q && cmpTrue);
endmodule // acr_control

// >>> design/acr_pkg.sv
// Purpose: Constants and types for the converter control and result block
// Assumes: One 100 MHz clock, synchronous active-high reset
// Notes: Register indices are byte addresses on the plain register port
// Operation
// [R1] Active flag set on start, cleared on end
// [R2] Trigger select: software write or hardware trigger
// [R3] Compare enable bit turns compare on
// [R4] Greater select: less-than or greater-or-equal
// [R5] Software writes zero to reserved bits
// [R6] Results update unless compare enabled and false
// [R7] High result holds bits nine:eight, zero in 8-bit
// [R8] Low result holds low eight bits
// [R9] High read blocks transfers until low read
// [R10] Result completing under block is discarded
// [R11] No interlock in 8-bit mode
// [R12] Results invalid after resolution change
// [R13] Upper compare bits used only in 10-bit
// [R14] Low compare bits always compared
// [R15] Low power select drives converter configuration
// [R16] Divide field divides converter clock by 1-8
// [R17] Long sample select sets sample period
// [R18] Resolution field: 00 8-bit, 10 10-bit
// [R19] Input clock select chooses converter clock source
// [R20] Complete flag set per compare, cleared by write/read
// [R21] First status write aborts, restarts unless off; the code restarts only with the software trigger selected
// [R22] Channel all ones turns converter off
// [R23] Active bit read-only, reads mostly side-effect free
// [R24] 10-bit compare is full unsigned value
package acr_pkg;
    localparam logic [2:0] ADDR_STATUS1   = 3'h0;
    localparam logic [2:0] ADDR_TRIGCMP   = 3'h1;
    localparam logic [2:0] ADDR_RESHIGH   = 3'h2;
    localparam logic [2:0] ADDR_RESLOW    = 3'h3;
    localparam logic [2:0] ADDR_CMPHIGH   = 3'h4;
    localparam logic [2:0] ADDR_CMPLOW    = 3'h5;
    localparam logic [2:0] ADDR_CONFIG    = 3'h6;
    localparam int BIT_COMPLETE  = 7;
    localparam int BIT_ACTIVE    = 7;
    localparam int BIT_TRIGSEL   = 6;
    localparam int BIT_CMPEN     = 5;
    localparam int BIT_CMPGT     = 4;
    localparam int BIT_LOWPOWER  = 7;
    localparam int BIT_LONGSAMP  = 4;
    localparam logic [1:0] RES_8BIT  = 2'h0;
    localparam logic [1:0] RES_10BIT = 2'h2;
    localparam logic [4:0] CHAN_OFF  = 5'h1F;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [4:0] RESET_CHAN = 5'h1F;
    // Bus command bundle
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } acr_bus_t;
    // Configuration register fields
    typedef struct packed {
        logic       lowPower;
        logic [1:0] clkDiv;
        logic       longSample;
        logic [1:0] resMode;
        logic [1:0] clkSel;
    } acr_cfg_t;
endpackage
